// file: core/sarp_regs.sv
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
// Operation
// RULE1: Volt1 code above upper limit while sensing on sets volt1 high flag.
// RULE2: Volt1 code below lower limit while sensing on sets volt1 low flag.
// RULE3: Keep highest volt1 reading, readable in the peak register.
// RULE4: Keep lowest volt1 reading, readable in the trough register.
// RULE5: Temp code above upper limit while monitor on sets temp high flag.
// RULE6: Temp code below lower limit while monitor on sets temp low flag.
// RULE7: Camera mask bit 5 enables missing frame alarm, set after reset.
// RULE8: Camera mask bits 4 and 3 enable PHY sync and control alarms.
// RULE9: Camera mask bits 2 to 0 enable ECC, checksum, length; default on.
// RULE10: Sensor mask bits 5 and 4 enable temp alarms, off after reset.
// RULE11: Sensor mask bits 3 and 2 enable volt1 alarms, off after reset.
// RULE12: Sensor mask bits 1 and 0 enable volt0 alarms, off after reset.
// RULE13: Back-channel mask bits 6 to 0 gate seven link alarms; off at reset.
// RULE14: High-speed swap bits 0-3 data lanes, bit 4 clock lane, default off.
// RULE15: Low-power invert bit 4 clock lane, bits 3:0 data lanes, default off.
// RULE16: An alarm is active only while its mask bit is one.
module sarp_regs
  import sarp_pkg::*;
#(
  parameter int READING_W = 8
) (
  // Clock and reset.
  input  wire logic                 clock,
  input  wire logic                 resetn,
  // AHB-Lite slave.
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // Sensor readings.
  input  wire logic [READING_W-1:0] volt1Reading,
  input  wire logic                 volt1Valid,
  input  wire logic [READING_W-1:0] tempReading,
  input  wire logic                 tempValid,
  // Detected conditions.
  input  wire sarp_events_t         events,
  // Alarms, lane polarity and interrupt.
  output logic      [5:0]           cameraAlarm,
  output logic      [5:0]           sensorAlarm,
  output logic      [6:0]           backchannelAlarm,
  output logic      [4:0]           hsLaneSwap,
  output logic      [4:0]           lpLaneInvert,
  output logic                      irq
);

  sarp_state_t s_reg;
  sarp_state_t s_next;
  logic [2:0]  volt1Code;
  logic [2:0]  tempCode;
  logic        addrTaken;
  logic [31:0] eventVec;

  // The sensors are compared at three-bit resolution, the limit width.
  assign volt1Code = volt1Reading[READING_W-1 -: 3];
  assign tempCode  = tempReading[READING_W-1 -: 3];
  assign addrTaken = hsel && htrans[1] && hready;

  // Read mux; it looks at the next state so a read right after a write
  // to the same register already sees the written value.
  function automatic logic [31:0] readWord(sarp_state_t st,
                                           logic [7:0] idx);
    logic [31:0] w;
    w = RST_WORD;
    case (idx)
      IDX_VOLT1_LIMIT:  w[7:0] = st.volt1Limit;
      IDX_TEMP_LIMIT:   w[7:0] = st.tempLimit;
      IDX_CAM_MASK:     w[7:0] = st.camMask;
      IDX_SENSE_MASK:   w[7:0] = st.senseMask;
      IDX_BC_MASK:      w[7:0] = st.bcMask;
      IDX_HS_POL:       w[4:0] = st.hsPol;
      IDX_LP_POL:       w[7:0] = st.lpPol;
      IDX_SENSE_CTRL:   w[1:0] = st.senseCtrl;
      IDX_PEAK:         w[7:0] = st.peak;
      IDX_TROUGH:       w[7:0] = st.trough;
      IDX_SENSE_STATUS: w[5:0] = st.senseFlags;
      IDX_IRQ_STATUS:   w      = st.irqStatus;
      IDX_IRQ_ENABLE:   w      = st.irqEnable;
      default:          w      = RST_WORD;
    endcase
    return w;
  endfunction

  // Next-state logic for the whole bank.
  always_comb begin
    logic [31:0] clearMask;
    logic [5:0]  flags;
    s_next    = s_reg;
    clearMask = RST_WORD;
    flags     = s_reg.senseFlags;

    // Register writes land in the data phase of the transfer.
    if (s_reg.wrPend) begin
      case (s_reg.wrIdx)
        IDX_VOLT1_LIMIT: s_next.volt1Limit = hwdata[7:0];
        IDX_TEMP_LIMIT:  s_next.tempLimit  = hwdata[7:0];
        IDX_CAM_MASK:    s_next.camMask    = hwdata[7:0];
        IDX_SENSE_MASK:  s_next.senseMask  = hwdata[7:0];
        IDX_BC_MASK:     s_next.bcMask     = hwdata[7:0];
        IDX_HS_POL:      s_next.hsPol      = hwdata[4:0]; // [RULE14]
        IDX_LP_POL:      s_next.lpPol      = hwdata[7:0]; // [RULE15]
        IDX_SENSE_CTRL:  s_next.senseCtrl  = hwdata[1:0];
        IDX_IRQ_ENABLE:  s_next.irqEnable  = hwdata;
        IDX_IRQ_CLEAR:   clearMask         = hwdata;
        default:         clearMask         = RST_WORD;
      endcase
    end

    // Second voltage input: limit checks and extremes.
    if (!s_reg.senseCtrl[CTRL_VOLT1_EN]) begin
      flags[SNS_VOLT1_HI] = 1'b0;
      flags[SNS_VOLT1_LO] = 1'b0;
    end else if (volt1Valid) begin
      flags[SNS_VOLT1_HI] = volt1Code >
        s_reg.volt1Limit[UPPER_LSB +: 3]; // [RULE1]
      flags[SNS_VOLT1_LO] = volt1Code <
        s_reg.volt1Limit[LOWER_LSB +: 3]; // [RULE2]
      if (volt1Reading > s_reg.peak) begin
        s_next.peak = volt1Reading; // [RULE3]
      end
      if (volt1Reading < s_reg.trough) begin
        s_next.trough = volt1Reading; // [RULE4]
      end
    end

    // Temperature monitor limit checks.
    if (!s_reg.senseCtrl[CTRL_TEMP_EN]) begin
      flags[SNS_TEMP_HI] = 1'b0;
      flags[SNS_TEMP_LO] = 1'b0;
    end else if (tempValid) begin
      flags[SNS_TEMP_HI] = tempCode >
        s_reg.tempLimit[UPPER_LSB +: 3]; // [RULE5]
      flags[SNS_TEMP_LO] = tempCode <
        s_reg.tempLimit[LOWER_LSB +: 3]; // [RULE6]
    end
    flags[SNS_VOLT0_HI] = events.volt0High;
    flags[SNS_VOLT0_LO] = events.volt0Low;
    s_next.senseFlags   = flags;

    // Masks gate each condition onto its alarm line.
    s_next.camAlarm   = events.camErr &
                        s_reg.camMask[5:0]; // [RULE7][RULE8][RULE9][RULE16]
    s_next.senseAlarm = s_reg.senseFlags & // [RULE10][RULE11]
                        s_reg.senseMask[5:0]; // [RULE12][RULE16]
    s_next.bcAlarm    = events.bcErr & s_reg.bcMask[6:0]; // [RULE13] [RULE16]

    // Sticky status; a new event wins over a clear in the same cycle.
    s_next.irqStatus = (s_reg.irqStatus & ~clearMask) | eventVec;
    s_next.irq       = |(s_next.irqStatus & s_next.irqEnable);

    // Bus: capture the address phase, answer with no wait states.
    s_next.hready = 1'b1;
    s_next.wrPend = addrTaken && hwrite;
    s_next.wrIdx  = haddr[9:2];
    if (addrTaken && !hwrite) begin
      s_next.hrdata = readWord(s_next, haddr[9:2]);
    end
  end

  // Events feeding the sticky status are the gated alarms.
  always_comb begin
    eventVec = RST_WORD;
    eventVec[IRQ_CAM_LSB +: 6]   = s_reg.camAlarm;
    eventVec[IRQ_SENSE_LSB +: 6] = s_reg.senseAlarm;
    eventVec[IRQ_BC_LSB +: 7]    = s_reg.bcAlarm;
  end

  // State register with synchronous reset.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_reg.volt1Limit <= RST_LIMIT;
      s_reg.tempLimit  <= RST_LIMIT;
      s_reg.camMask    <= RST_CAM_MASK;   // [RULE7] [RULE8] [RULE9]
      s_reg.senseMask  <= RST_SENSE_MASK; // [RULE10] [RULE11] [RULE12]
      s_reg.bcMask     <= RST_BC_MASK;    // [RULE13]
      s_reg.hsPol      <= RST_HS_POL;     // [RULE14]
      s_reg.lpPol      <= RST_LP_POL;     // [RULE15]
      s_reg.senseCtrl  <= RST_SENSE_CTRL;
      s_reg.peak       <= RST_PEAK;
      s_reg.trough     <= RST_TROUGH;
      s_reg.senseFlags <= 6'h00;
      s_reg.irqStatus  <= RST_WORD;
      s_reg.irqEnable  <= RST_WORD;
      s_reg.camAlarm   <= 6'h00;
      s_reg.senseAlarm <= 6'h00;
      s_reg.bcAlarm    <= 7'h00;
      s_reg.irq        <= 1'b0;
      s_reg.wrPend     <= 1'b0;
      s_reg.wrIdx      <= 8'h00;
      s_reg.hrdata     <= RST_WORD;
      s_reg.hready     <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state flops, except hresp, which is tied low.
  assign hrdata           = s_reg.hrdata;
  assign hreadyout        = s_reg.hready;
  assign hresp            = 1'b0;
  assign cameraAlarm      = s_reg.camAlarm;
  assign sensorAlarm      = s_reg.senseAlarm;
  assign backchannelAlarm = s_reg.bcAlarm;
  assign hsLaneSwap       = s_reg.hsPol;
  assign lpLaneInvert     = s_reg.lpPol[4:0];
  assign irq              = s_reg.irq;

  // Checks on the bank's own behaviour.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_volt1_high;
    volt1Valid && s_reg.senseCtrl[CTRL_VOLT1_EN] &&
      (volt1Code > s_reg.volt1Limit[6:4]) |=> s_reg.senseFlags[3];
  endproperty
  a_volt1_high: assert property (p_volt1_high) // [RULE1]
    else $error("volt1 high flag not raised");

  property p_volt1_low;
    volt1Valid && s_reg.senseCtrl[CTRL_VOLT1_EN] &&
      (volt1Code < s_reg.volt1Limit[2:0]) |=> s_reg.senseFlags[2];
  endproperty
  a_volt1_low: assert property (p_volt1_low) // [RULE2]
    else $error("volt1 low flag not raised");

  property p_peak;
    volt1Valid && s_reg.senseCtrl[0] && !s_reg.wrPend |=>
      s_reg.peak >= $past(volt1Reading);
  endproperty
  a_peak: assert property (p_peak) // [RULE3]
    else $error("peak reading missed a higher sample");

  property p_trough;
    volt1Valid && s_reg.senseCtrl[0] |=>
      s_reg.trough <= $past(volt1Reading);
  endproperty
  a_trough: assert property (p_trough) // [RULE4]
    else $error("trough reading missed a lower sample");

  property p_temp_high;
    tempValid && s_reg.senseCtrl[CTRL_TEMP_EN] &&
      (tempCode > s_reg.tempLimit[6:4]) |=> s_reg.senseFlags[5];
  endproperty
  a_temp_high: assert property (p_temp_high) // [RULE5]
    else $error("temperature high flag not raised");

  property p_temp_low;
    tempValid && s_reg.senseCtrl[CTRL_TEMP_EN] &&
      (tempCode < s_reg.tempLimit[2:0]) |=> s_reg.senseFlags[4];
  endproperty
  a_temp_low: assert property (p_temp_low) // [RULE6]
    else $error("temperature low flag not raised");

  property p_cam_gate;
    ##1 cameraAlarm == ($past(events.camErr) & $past(s_reg.camMask[5:0]));
  endproperty
  a_cam_gate: assert property (p_cam_gate) // [RULE16]
    else $error("camera alarm not gated by its mask");

  property p_bc_gate;
    !s_reg.bcMask[6] |=> !backchannelAlarm[6];
  endproperty
  a_bc_gate: assert property (p_bc_gate) // [RULE13]
    else $error("back-channel alarm passed a cleared mask bit");

  property p_sense_gate;
    !s_reg.senseMask[5] |=> !sensorAlarm[5];
  endproperty
  a_sense_gate: assert property (p_sense_gate) // [RULE10]
    else $error("temperature alarm passed a cleared mask bit");

  property p_hs_lanes;
    s_reg.wrPend && (s_reg.wrIdx == IDX_HS_POL) |=>
      hsLaneSwap == $past(hwdata[4:0]);
  endproperty
  a_hs_lanes: assert property (p_hs_lanes) // [RULE14]
    else $error("high-speed swap output missed a register write");

  property p_lp_lanes;
    s_reg.wrPend && (s_reg.wrIdx == IDX_LP_POL) |=>
      lpLaneInvert == $past(hwdata[4:0]);
  endproperty
  a_lp_lanes: assert property (p_lp_lanes) // [RULE15]
    else $error("low-power invert output missed a register write");

  property p_status_set;
    cameraAlarm[0] |=> s_reg.irqStatus[IRQ_CAM_LSB];
  endproperty
  a_status_set: assert property (p_status_set) // [RULE9]
    else $error("status bit not set by its alarm");

  // A legal clear may drop the bit, so the hold is only demanded while no
  // clear of that bit is landing in the same cycle.
  property p_sticky;
    s_reg.irqStatus[IRQ_CAM_LSB] &&
      !(s_reg.wrPend && (s_reg.wrIdx == IDX_IRQ_CLEAR) && hwdata[0]) |=>
      s_reg.irqStatus[IRQ_CAM_LSB];
  endproperty
  a_sticky: assert property (p_sticky) // [RULE9]
    else $error("status bit lost before a clear");

  property p_volt1_off;
    !s_reg.senseCtrl[CTRL_VOLT1_EN] |=>
      !s_reg.senseFlags[SNS_VOLT1_HI] && !s_reg.senseFlags[SNS_VOLT1_LO];
  endproperty
  a_volt1_off: assert property (p_volt1_off) // [RULE1] [RULE2]
    else $error("volt1 flag set while sensing is off");

  property p_temp_off;
    !s_reg.senseCtrl[CTRL_TEMP_EN] |=>
      !s_reg.senseFlags[SNS_TEMP_HI] && !s_reg.senseFlags[SNS_TEMP_LO];
  endproperty
  a_temp_off: assert property (p_temp_off) // [RULE5] [RULE6]
    else $error("temperature flag set while monitor is off");

  property p_volt1_gate;
    !s_reg.senseMask[SNS_VOLT1_HI] |=> !sensorAlarm[SNS_VOLT1_HI];
  endproperty
  a_volt1_gate: assert property (p_volt1_gate) // [RULE11]
    else $error("volt1 alarm passed a cleared mask bit");

  property p_volt0_gate;
    !s_reg.senseMask[SNS_VOLT0_LO] |=> !sensorAlarm[SNS_VOLT0_LO];
  endproperty
  a_volt0_gate: assert property (p_volt0_gate) // [RULE12]
    else $error("volt0 alarm passed a cleared mask bit");

  // The first edge after reset must already show every mask default.
  property p_mask_reset;
    $rose(resetn) |-> (s_reg.camMask == RST_CAM_MASK) &&
      (s_reg.senseMask == RST_SENSE_MASK) && (s_reg.bcMask == RST_BC_MASK);
  endproperty
  a_mask_reset: assert property (p_mask_reset) // [RULE7] [RULE10] [RULE13]
    else $error("alarm masks wrong after reset");

  property p_pol_reset;
    $rose(resetn) |-> (hsLaneSwap == RST_HS_POL) &&
      (lpLaneInvert == RST_LP_POL[4:0]);
  endproperty
  a_pol_reset: assert property (p_pol_reset) // [RULE14] [RULE15]
    else $error("lane polarity not at default after reset");

  c_cam_alarm: cover property (cameraAlarm[5]);
  c_temp_alarm: cover property (sensorAlarm[5] ##1
    s_reg.irqStatus[IRQ_SENSE_LSB + SNS_TEMP_HI]);
  c_write_read: cover property (s_reg.wrPend ##2 (addrTaken && !hwrite));
  c_bc_alarm: cover property (backchannelAlarm[6]);

endmodule // sarp_regs

// file: core/sarp_pkg.sv
package sarp_pkg;

  // Register word indices; the byte address is four times the index.
  localparam logic [7:0] IDX_VOLT1_LIMIT   = 8'h1A;
  localparam logic [7:0] IDX_TEMP_LIMIT    = 8'h1B;
  localparam logic [7:0] IDX_CAM_MASK      = 8'h1C;
  localparam logic [7:0] IDX_SENSE_MASK    = 8'h1D;
  localparam logic [7:0] IDX_BC_MASK       = 8'h1E;
  localparam logic [7:0] IDX_HS_POL        = 8'h20;
  localparam logic [7:0] IDX_LP_POL        = 8'h21;
  localparam logic [7:0] IDX_SENSE_CTRL    = 8'h40;
  localparam logic [7:0] IDX_PEAK          = 8'h41;
  localparam logic [7:0] IDX_TROUGH        = 8'h42;
  localparam logic [7:0] IDX_SENSE_STATUS  = 8'h43;
  localparam logic [7:0] IDX_IRQ_STATUS    = 8'h44;
  localparam logic [7:0] IDX_IRQ_ENABLE    = 8'h45;
  localparam logic [7:0] IDX_IRQ_CLEAR     = 8'h46;

  // Limit field positions, shared by both limit registers.
  localparam int UPPER_LSB = 4;
  localparam int LOWER_LSB = 0;

  // Sensor flag and sensor mask bit positions.
  localparam int SNS_TEMP_HI  = 5;
  localparam int SNS_TEMP_LO  = 4;
  localparam int SNS_VOLT1_HI = 3;
  localparam int SNS_VOLT1_LO = 2;
  localparam int SNS_VOLT0_HI = 1;
  localparam int SNS_VOLT0_LO = 0;

  // Sensing control bits.
  localparam int CTRL_VOLT1_EN = 0;
  localparam int CTRL_TEMP_EN  = 1;

  // Interrupt layout: camera group, sensor group, back-channel group.
  localparam int IRQ_CAM_LSB   = 0;
  localparam int IRQ_SENSE_LSB = 8;
  localparam int IRQ_BC_LSB    = 16;

  // Values after reset.
  localparam logic [7:0]  RST_LIMIT      = 8'h62;
  localparam logic [7:0]  RST_CAM_MASK   = 8'h3F;
  localparam logic [7:0]  RST_SENSE_MASK = 8'h00;
  localparam logic [7:0]  RST_BC_MASK    = 8'h00;
  localparam logic [4:0]  RST_HS_POL     = 5'h00;
  localparam logic [7:0]  RST_LP_POL     = 8'h00;
  localparam logic [1:0]  RST_SENSE_CTRL = 2'h2;
  localparam logic [7:0]  RST_PEAK       = 8'h00;
  localparam logic [7:0]  RST_TROUGH     = 8'hFF;
  localparam logic [31:0] RST_WORD       = 32'h0000_0000;

  // Complete state of the register bank.
  typedef struct packed {
    logic [7:0]  volt1Limit;
    logic [7:0]  tempLimit;
    logic [7:0]  camMask;
    logic [7:0]  senseMask;
    logic [7:0]  bcMask;
    logic [4:0]  hsPol;
    logic [7:0]  lpPol;
    logic [1:0]  senseCtrl;
    logic [7:0]  peak;
    logic [7:0]  trough;
    logic [5:0]  senseFlags;
    logic [31:0] irqStatus;
    logic [31:0] irqEnable;
    logic [5:0]  camAlarm;
    logic [5:0]  senseAlarm;
    logic [6:0]  bcAlarm;
    logic        irq;
    logic        wrPend;
    logic [7:0]  wrIdx;
    logic [31:0] hrdata;
    logic        hready;
  } sarp_state_t;

  // Detected conditions arriving from the neighbouring blocks.
  typedef struct packed {
    logic [5:0] camErr;
    logic [6:0] bcErr;
    logic       volt0High;
    logic       volt0Low;
  } sarp_events_t;

endpackage

// file: tb/sensor_alarm_polarity_regs_tb.sv
`timescale 1ns/1ps
module sensor_alarm_polarity_regs_tb;
  import sarp_pkg::*;
  // Bench clock, reset and bus master signals.
  logic         clock        = 1'b0;
  logic         resetn       = 1'b0;
  logic         hsel         = 1'b0;
  logic [31:0]  haddr        = 32'h0;
  logic [1:0]   htrans       = 2'h0;
  logic         hwrite       = 1'b0;
  logic [31:0]  hwdata       = 32'h0;
  logic [31:0]  hrdata;
  logic         hreadyout;
  logic         hresp;
  logic [7:0]   volt1Reading = 8'h00;
  logic         volt1Valid   = 1'b0;
  logic [7:0]   tempReading  = 8'h00;
  logic         tempValid    = 1'b0;
  sarp_events_t events       = '0;
  logic [5:0]   cameraAlarm;
  logic [5:0]   sensorAlarm;
  logic [6:0]   backchannelAlarm;
  logic [4:0]   hsLaneSwap;
  logic [4:0]   lpLaneInvert;
  logic         irq;
  logic         rdPend       = 1'b0;
  logic [31:0]  seed         = 32'h0000CA98;
  logic [31:0]  expQ[$];
  int           fails        = 0;
  int           n_checks     = 0;

  sarp_regs i_sarp_regs (.clock(clock), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .volt1Reading(volt1Reading),
    .volt1Valid(volt1Valid), .tempReading(tempReading),
    .tempValid(tempValid), .events(events), .cameraAlarm(cameraAlarm),
    .sensorAlarm(sensorAlarm), .backchannelAlarm(backchannelAlarm),
    .hsLaneSwap(hsLaneSwap), .lpLaneInvert(lpLaneInvert), .irq(irq));

  // Free running 40 MHz clock.
  always #12.5 clock = ~clock;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One single word transfer; waits on hready, never on a fixed count.
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [31:0] d);
    @(posedge clock);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {22'h0, idx, 2'h0};
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d);
  endtask

  // The expected word is noted first; the monitor compares it.
  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    expQ.push_back(e);
    xfer(1'b0, idx, 32'h0);
  endtask

  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask

  // One sample of both sensors, then time for flags and alarms.
  task automatic sample(input logic [7:0] v, input logic [7:0] t);
    @(posedge clock);
    volt1Reading <= v;
    tempReading  <= t;
    volt1Valid   <= 1'b1;
    tempValid    <= 1'b1;
    @(posedge clock);
    volt1Valid   <= 1'b0;
    tempValid    <= 1'b0;
    settle();
  endtask

  // Read data stands in the data phase, so it is taken one edge late.
  always @(posedge clock) begin
    if (rdPend) begin
      check(hrdata, expQ.pop_front());
      check({31'h0, hresp}, 32'h0);
      check({31'h0, hreadyout}, 32'h1);
    end
    rdPend <= hsel && htrans[1] && !hwrite && hreadyout;
  end

  // A stall must not hang the run; the budget is far above the need.
  initial begin
    #(25 * 20000);
    fails++;
    stop_test();
  end

  localparam logic [7:0] RIDX [15] = '{IDX_VOLT1_LIMIT, IDX_TEMP_LIMIT,
    IDX_CAM_MASK, IDX_SENSE_MASK, IDX_BC_MASK, IDX_HS_POL, IDX_LP_POL,
    IDX_SENSE_CTRL, IDX_PEAK, IDX_TROUGH, IDX_SENSE_STATUS,
    IDX_IRQ_STATUS, IDX_IRQ_ENABLE, IDX_IRQ_CLEAR, 8'h30};
  localparam logic [7:0] RVAL [15] = '{8'h62, 8'h62, 8'h3F, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h02, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] WMSK [7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'h1F, 8'hFF};
  localparam logic [7:0] SRD [4] = '{8'hE0, 8'h10, 8'h40, 8'hC0};
  localparam logic [5:0] SFL [4] = '{6'h28, 6'h14, 6'h00, 6'h00};

  initial begin
    logic [31:0] wv [7];
    logic [31:0] m;
    logic [31:0] e;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    #1;
    check({cameraAlarm, sensorAlarm, backchannelAlarm, irq}, 32'h0);
    check({hsLaneSwap, lpLaneInvert}, 32'h0);
    // Reset values, an unmapped word and the write-only clear word.
    foreach (RIDX[i]) begin
      rd(RIDX[i], {24'h0, RVAL[i]});
    end
    // Random write and read back of the seven limit, mask and polarity words.
    foreach (WMSK[i]) begin
      wv[i] = rnd();
      wr(RIDX[i], wv[i]);
      rd(RIDX[i], wv[i] & {24'h0, WMSK[i]});
    end
    settle();
    check({27'h0, hsLaneSwap}, {27'h0, wv[5][4:0]});
    check({27'h0, lpLaneInvert}, {27'h0, wv[6][4:0]});
    wr(IDX_PEAK, 32'h55);
    rd(IDX_PEAK, 32'h0);
    // Random masks against random detected conditions.
    repeat (8) begin
      m = rnd();
      e = rnd();
      wr(IDX_CAM_MASK, m);
      wr(IDX_BC_MASK, m >> 8);
      wr(IDX_SENSE_MASK, m >> 16);
      @(posedge clock);
      events <= e[14:0];
      settle();
      check({26'h0, cameraAlarm}, {26'h0, e[14:9] & m[5:0]});
      check({25'h0, backchannelAlarm}, {25'h0, e[8:2] & m[14:8]});
      check({30'h0, sensorAlarm[1:0]}, {30'h0, e[1:0] & m[17:16]});
    end
    @(posedge clock);
    events <= '0;
    // Limit crossings, equal-to-limit boundaries, peak and trough.
    wr(IDX_VOLT1_LIMIT, 32'h62);
    wr(IDX_TEMP_LIMIT, 32'h62);
    wr(IDX_SENSE_CTRL, 32'h3);
    wr(IDX_SENSE_MASK, 32'h3C);
    foreach (SRD[i]) begin
      sample(SRD[i], SRD[i]);
      check({26'h0, sensorAlarm}, {26'h0, SFL[i]});
      rd(IDX_SENSE_STATUS, {26'h0, SFL[i]});
    end
    rd(IDX_PEAK, 32'hE0);
    rd(IDX_TROUGH, 32'h10);
    // Disabled sensing clears flags and freezes the peak.
    wr(IDX_SENSE_CTRL, 32'h0);
    sample(8'hFF, 8'hFF);
    check({26'h0, sensorAlarm}, 32'h0);
    rd(IDX_PEAK, 32'hE0);
    // Interrupt: clear, raise, mask, unmask and clear again.
    wr(IDX_IRQ_CLEAR, 32'hFFFFFFFF);
    rd(IDX_IRQ_STATUS, 32'h0);
    wr(IDX_CAM_MASK, 32'h3F);
    wr(IDX_IRQ_ENABLE, 32'h1);
    @(posedge clock);
    events.camErr <= 6'h01;
    @(posedge clock);
    events.camErr <= 6'h00;
    settle();
    check({31'h0, irq}, 32'h1);
    rd(IDX_IRQ_STATUS, 32'h1);
    wr(IDX_IRQ_ENABLE, 32'h0);
    settle();
    check({31'h0, irq}, 32'h0);
    wr(IDX_IRQ_ENABLE, 32'h1);
    settle();
    check({31'h0, irq}, 32'h1);
    wr(IDX_IRQ_CLEAR, 32'h1);
    settle();
    check({31'h0, irq}, 32'h0);
    rd(IDX_IRQ_STATUS, 32'h0);
    repeat (2) @(posedge clock);
    stop_test();
  end
endmodule // sensor_alarm_polarity_regs_tb
